// ---- adcc_defs.svh ----
// register map, field positions, reset values and counts of the conversion controller
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

`define ADCC_ADDR_W 5
`define ADCC_OFF_CTRL 5'h00
`define ADCC_OFF_MODE 5'h04
`define ADCC_OFF_RESH 5'h08
`define ADCC_OFF_RESL 5'h0c
`define ADCC_OFF_ISTAT 5'h10
`define ADCC_OFF_IMASK 5'h14

`define ADCC_CTRL_EN_BIT 7
`define ADCC_CTRL_START_BIT 6
`define ADCC_CTRL_CHAN_MSB 3
`define ADCC_CHAN_W 4
`define ADCC_NUM_CHAN 4'hc
`define ADCC_CHAN_BANDGAP 4'hb

`define ADCC_MODE_DIV_MSB 2
`define ADCC_DIV_SEL_W 3
`define ADCC_DIV_CNT_W 7
`define ADCC_DIV_RATIOS 8

`define ADCC_RES_W 12
`define ADCC_RES_TOP 4'hb
`define ADCC_RES_SPLIT 4
`define ADCC_BYTE_W 8
`define ADCC_IRQ_CONV_BIT 3

`define ADCC_CTRL_RST 5'h00
`define ADCC_DIV_RST 3'h0
`define ADCC_BYTE_RST 8'h00
`define ADCC_RES_RST 12'h000
`define ADCC_WORD_ZERO 32'h0000_0000
`define ADCC_NIB_ZERO 4'h0
`define ADCC_IDX_ZERO 4'h0

`endif

// ---- adcc_pkg.sv ----
// types shared by the conversion controller, its checker, the front-end model and the bench
package adcc_pkg;
  `include "adcc_defs.svh"

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ = 2'b01,
    ST_CONV = 2'b10
  } adcc_state_t;

  typedef struct packed {
    logic enable;
    logic [`ADCC_CHAN_W-1:0] chan;
  } adcc_ctrl_t;

  typedef struct packed {
    logic sample;
    logic [`ADCC_CHAN_W-1:0] chan;
    logic [`ADCC_RES_W-1:0] dacCode;
  } adcc_afe_t;
endpackage

// ---- adcc_clk_div.sv ----
// conversion clock tick generator, divide by 2^sel of the system clock
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_clk_div
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic run,
  input wire logic [`ADCC_DIV_SEL_W-1:0] divSel,
  // one-cycle tick at the end of each conversion clock period
  output logic tick
);
  logic [`ADCC_DIV_CNT_W-1:0] cnt_reg;
  logic [`ADCC_DIV_CNT_W-1:0] cnt_next;
  logic [`ADCC_DIV_RATIOS-1:0] hit;

  // ratio i ends its period when the low i counter bits are all ones
  genvar i;
  generate
    for (i = 0; i < `ADCC_DIV_RATIOS; i++) begin : gHit
      if (i == 0) begin : gOne
        assign hit[i] = 1'b1;
      end else begin : gMany
        assign hit[i] = &cnt_reg[i-1:0];
      end
    end
  endgenerate

  // combinational tick so a divide-by-1 period is exactly one cycle
  assign tick = run & hit[divSel];

  always_comb begin
    cnt_next = cnt_reg + 1'b1;
    // restart from zero so every phase starts on a period boundary
    if (!run) begin
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// ---- adcc_conv_ctrl.sv ----
// successive approximation converter control with Avalon-MM register slave
//
// What this block does
// - writing one to control bit 6 starts a conversion; it reads one when done
// - conversion clock is system clock divided by 1,2,4..128, set by mode field
// - sampling phase lasts exactly one conversion clock period
// - twelve channels: eleven external pins and the internal bandgap input
// - channel select and enable live in control fields apart from start/done
// - reference is always the supply; bandgap is only an input channel
// - 12-bit unsigned code, full swing 4096 at input equal to reference
// - result left-justified over high and low result registers, 16 bits
// - writing zero to the whole control register disables the converter
// - finished conversion sets interrupt status bit 3 regardless of mask
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_conv_ctrl
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [`ADCC_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // analog front end
  output adcc_afe_t afe,
  input wire logic compHigh,
  // interrupt
  output logic irq
);

  // bus slave state
  logic waitReq_reg;
  logic waitReq_next;
  logic [31:0] readData_reg;
  logic [31:0] readData_next;

  // software registers
  adcc_ctrl_t ctrl_reg;
  adcc_ctrl_t ctrl_next;
  logic [`ADCC_DIV_SEL_W-1:0] divSel_reg;
  logic [`ADCC_DIV_SEL_W-1:0] divSel_next;
  logic [`ADCC_BYTE_W-1:0] irqStat_reg;
  logic [`ADCC_BYTE_W-1:0] irqStat_next;
  logic [`ADCC_BYTE_W-1:0] irqMask_reg;
  logic [`ADCC_BYTE_W-1:0] irqMask_next;

  // conversion engine
  adcc_state_t state_reg;
  adcc_state_t state_next;
  logic [`ADCC_CHAN_W-1:0] bitIdx_reg;
  logic [`ADCC_CHAN_W-1:0] bitIdx_next;
  logic [`ADCC_RES_W-1:0] dac_reg;
  logic [`ADCC_RES_W-1:0] dac_next;
  logic [`ADCC_RES_W-1:0] result_reg;
  logic [`ADCC_RES_W-1:0] result_next;
  logic done_reg;
  logic done_next;

  // outputs
  adcc_afe_t afe_reg;
  adcc_afe_t afe_next;
  logic irq_reg;
  logic irq_next;

  // internal strobes
  logic wrAcc;
  logic rdLoad;
  logic ctrlWr;
  logic startReq;
  logic convEnd;
  logic tick;
  logic running;
  logic [`ADCC_BYTE_W-1:0] ctrlRead;
  logic [`ADCC_BYTE_W-1:0] resHigh;
  logic [`ADCC_BYTE_W-1:0] resLow;

  assign readdata = readData_reg;
  assign waitrequest = waitReq_reg;
  assign afe = afe_reg;
  assign irq = irq_reg;

  // one wait state: read data is fetched while waitrequest is high
  assign rdLoad = read & waitReq_reg;
  assign wrAcc = write & ~waitReq_reg & byteenable[0];
  assign ctrlWr = wrAcc && (address == `ADCC_OFF_CTRL);

  // start only from idle with the converter enabled and a real channel
  assign startReq = ctrlWr && writedata[`ADCC_CTRL_START_BIT]
                    && writedata[`ADCC_CTRL_EN_BIT]
                    && (writedata[`ADCC_CTRL_CHAN_MSB:0] < `ADCC_NUM_CHAN)
                    && (state_reg == ST_IDLE);

  assign running = (state_reg != ST_IDLE);
  assign convEnd = (state_reg == ST_CONV) && tick && (bitIdx_reg == `ADCC_IDX_ZERO);

  // control read: enable, start/done, two reserved zeros, channel
  assign ctrlRead = {ctrl_reg.enable, done_reg, 2'b00, ctrl_reg.chan};
  // 12-bit code left-justified over two bytes; software shifts right by 4
  assign resHigh = result_reg[`ADCC_RES_W-1:`ADCC_RES_SPLIT];
  assign resLow = {result_reg[`ADCC_RES_SPLIT-1:0], `ADCC_NIB_ZERO};

  adcc_clk_div uDiv (
    .clk(clk),
    .srst(srst),
    .run(running),
    .divSel(divSel_reg),
    .tick(tick)
  );

  // bus slave
  always_comb begin
    waitReq_next = ~((read | write) & waitReq_reg);
    readData_next = readData_reg;
    if (rdLoad) begin
      case (address)
        `ADCC_OFF_CTRL: readData_next = {24'h00_0000, ctrlRead};
        `ADCC_OFF_MODE: readData_next = {29'h0000_0000, divSel_reg};
        `ADCC_OFF_RESH: readData_next = {24'h00_0000, resHigh};
        `ADCC_OFF_RESL: readData_next = {24'h00_0000, resLow};
        `ADCC_OFF_ISTAT: readData_next = {24'h00_0000, irqStat_reg};
        `ADCC_OFF_IMASK: readData_next = {24'h00_0000, irqMask_reg};
        default: readData_next = `ADCC_WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      waitReq_reg <= 1'b1;
      readData_reg <= `ADCC_WORD_ZERO;
    end else begin
      waitReq_reg <= waitReq_next;
      readData_reg <= readData_next;
    end
  end

  // software registers
  always_comb begin
    ctrl_next = ctrl_reg;
    divSel_next = divSel_reg;
    irqMask_next = irqMask_reg;
    irqStat_next = irqStat_reg;
    if (ctrlWr) begin
      // a write of zero clears enable and aborts any conversion
      ctrl_next.enable = writedata[`ADCC_CTRL_EN_BIT];
      ctrl_next.chan = writedata[`ADCC_CTRL_CHAN_MSB:0];
    end
    if (wrAcc && (address == `ADCC_OFF_MODE)) begin
      // a change mid-conversion takes effect at once; the current period ends at the new ratio's next tick
      divSel_next = writedata[`ADCC_MODE_DIV_MSB:0];
    end
    if (wrAcc && (address == `ADCC_OFF_IMASK)) begin
      irqMask_next = writedata[`ADCC_BYTE_W-1:0];
    end
    if (wrAcc && (address == `ADCC_OFF_ISTAT)) begin
      irqStat_next = irqStat_reg & ~writedata[`ADCC_BYTE_W-1:0];
    end
    // set after clear so an event in the clearing cycle survives
    if (convEnd) begin
      irqStat_next[`ADCC_IRQ_CONV_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= `ADCC_CTRL_RST;
      divSel_reg <= `ADCC_DIV_RST;
      irqStat_reg <= `ADCC_BYTE_RST;
      irqMask_reg <= `ADCC_BYTE_RST;
    end else begin
      ctrl_reg <= ctrl_next;
      divSel_reg <= divSel_next;
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
    end
  end

  // conversion engine: sample one period, then one trial per period from msb down
  always_comb begin
    state_next = state_reg;
    bitIdx_next = bitIdx_reg;
    dac_next = dac_reg;
    result_next = result_reg;
    done_next = done_reg;
    case (state_reg)
      ST_IDLE: begin
        if (startReq) begin
          state_next = ST_ACQ;
          done_next = 1'b0;
        end
      end
      ST_ACQ: begin
        // sampling ends on the first tick, one full period after start
        if (tick) begin
          state_next = ST_CONV;
          bitIdx_next = `ADCC_RES_TOP;
          dac_next = '0;
          dac_next[`ADCC_RES_TOP] = 1'b1;
        end
      end
      ST_CONV: begin
        if (tick) begin
          // trial level is code/4096 of the supply reference
          if (!compHigh) begin
            dac_next[bitIdx_reg] = 1'b0;
          end
          if (bitIdx_reg == `ADCC_IDX_ZERO) begin
            state_next = ST_IDLE;
            done_next = 1'b1;
            // result moves only here, together with the done bit
            result_next = dac_next;
          end else begin
            bitIdx_next = bitIdx_reg - 1'b1;
            dac_next[bitIdx_next] = 1'b1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // disable wins over everything; result and done are left alone
    if (!ctrl_next.enable) begin
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      bitIdx_reg <= `ADCC_IDX_ZERO;
      dac_reg <= `ADCC_RES_RST;
      result_reg <= `ADCC_RES_RST;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bitIdx_reg <= bitIdx_next;
      dac_reg <= dac_next;
      result_reg <= result_next;
      done_reg <= done_next;
    end
  end

  // registered outputs to the front end and the interrupt line
  always_comb begin
    afe_next.sample = (state_next == ST_ACQ);
    // channel 11 is the bandgap; the reference has no select, it is the supply
    afe_next.chan = ctrl_next.chan;
    afe_next.dacCode = dac_next;
    irq_next = |(irqStat_next & irqMask_next);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      afe_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      afe_reg <= afe_next;
      irq_reg <= irq_next;
    end
  end
endmodule

// ---- adcc_conv_ctrl_chk.sv ----
// port-level assertions for the conversion controller
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_conv_ctrl_chk
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic [`ADCC_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // front end and interrupt
  input wire adcc_afe_t afe,
  input wire logic compHigh,
  input wire logic irq
);
  logic [2:0] divSel_reg;
  logic [7:0] maskBits_reg;
  logic [7:0] sampCnt_reg;
  logic wrTake;
  logic abortTake;
  assign wrTake = write && !waitrequest && byteenable[0];
  // a control write with enable low cuts sampling short on purpose
  assign abortTake = wrTake && address == 5'h00 && !writedata[7];
  // shadows of mode and mask, taken on the same edge as the slave
  always_ff @(posedge clk) begin
    if (srst) begin
      divSel_reg <= 3'h0;
      maskBits_reg <= 8'h00;
      sampCnt_reg <= 8'h00;
    end else begin
      if (wrTake && address == 5'h04) divSel_reg <= writedata[2:0];
      if (wrTake && address == 5'h14) maskBits_reg <= writedata[7:0];
      sampCnt_reg <= afe.sample ? sampCnt_reg + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_wait_single: assert property (!waitrequest |=> waitrequest) else $error("wait low too long");
  a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer");
  a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_unmapped_read: assert property (read && !waitrequest && address > 5'h14
    |-> readdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_start_cause: assert property ($rose(afe.sample) |->
    $past(wrTake && address == 5'h00 && writedata[7:6] == 2'b11)) else $error("stray sample");
  a_sample_len: assert property ($fell(afe.sample) && !$past(abortTake) |->
    sampCnt_reg == (8'h01 << divSel_reg)) else $error("sampling length wrong");
  a_first_trial: assert property ($fell(afe.sample) && !$past(abortTake) |->
    afe.dacCode == 12'h800) else $error("first trial not midscale");
  a_chan_valid: assert property (afe.sample |-> afe.chan < 4'hc)
    else $error("sampling bad channel");
  a_abort_idle: assert property (wrTake && address == 5'h00 && !writedata[7]
    |=> !afe.sample) else $error("disable did not stop");
  a_irq_masked: assert property (maskBits_reg == 8'h00 && $past(maskBits_reg) == 8'h00
    |-> !irq) else $error("irq while masked");
endmodule

bind adcc_conv_ctrl adcc_conv_ctrl_chk u_chk (.clk, .srst, .address, .read, .write,
  .writedata, .byteenable, .readdata, .waitrequest, .afe, .compHigh, .irq);

// ---- adcc_afe_model.sv ----
// analog side model: comparator of input level against the trial code
`timescale 1ns/1ps
module adcc_afe_model
  import adcc_pkg::*;
(
  // from the controller
  input wire adcc_afe_t afe,
  // input level in codes of the supply; ideal pin: input, no pulls, digital path off
  input wire logic [11:0] level,
  // comparator
  output logic compHigh
);
  // reference is always the supply, so the level compares straight to the code
  assign compHigh = (level >= afe.dacCode);
endmodule

// ---- adcc_conv_ctrl_tb.sv ----
// self-checking bench for the conversion controller
`timescale 1ns/1ps
`include "adcc_defs.svh"
module adcc_conv_ctrl_tb
  import adcc_pkg::*;
;
  logic clk, srst, read, write, compHigh, irq, waitrequest;
  logic [4:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable, ch;
  logic [11:0] lvlBase, level, expRes;
  adcc_afe_t afe;
  int num_errors, n_tests, i, s;
  // each channel sits 128 codes above the last, so a wrong mux shows
  assign level = lvlBase + 12'({afe.chan, 7'h00});
  adcc_conv_ctrl dut (.clk(clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .afe(afe), .compHigh(compHigh), .irq(irq));
  adcc_afe_model u_afe (.afe(afe), .level(level), .compHigh(compHigh));
  always #2.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    if (num_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d, input logic be);
    int k;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h00_0000, d};
    byteenable <= {3'h0, be};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // a slave that never answers ends the run as a failure
    if (k >= 20) begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 1'b1);
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, 1'b1);
    check(q, {24'h00_0000, e});
  endtask
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
    lvlBase = 12'h0a5;
    num_errors = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    for (i = 0; i < 8; i++) rdchk(5'(i * 4), 8'h00);
    for (s = 0; s < 8; s++) begin
      ch = 4'(s + 4);
      lvlBase <= 12'h0a5 + 12'(s * 315);
      wr(5'h14, {4'h0, 1'(s), 3'h0});
      wr(5'h04, 8'(s));
      rdchk(5'h04, 8'(s));
      wr(5'h00, {4'hc, ch});
      rdchk(5'h00, {4'h8, ch});
      i = 0;
      do begin
        acc(1'b0, 5'h00, 8'h00, 1'b1);
        i++;
      end while (q[6] !== 1'b1 && i < 1000);
      check(q, {24'h00_0000, 4'hc, ch});
      expRes = lvlBase + 12'({ch, 7'h00});
      rdchk(5'h08, expRes[11:4]);
      rdchk(5'h0c, {expRes[3:0], 4'h0});
      rdchk(5'h10, 8'h08);
      check(32'(irq), 32'(s % 2));
      wr(5'h10, 8'h08);
      rdchk(5'h10, 8'h00);
      check(32'(irq), 32'h0000_0000);
    end
    // ignored write with byte lane off
    acc(1'b1, 5'h04, 8'h03, 1'b0);
    rdchk(5'h04, 8'h07);
    lvlBase <= 12'h777;
    wr(5'h00, 8'hcc);
    rdchk(5'h00, 8'hcc);
    wr(5'h00, 8'h45);
    rdchk(5'h00, 8'h45);
    wr(5'h00, 8'hc3);
    wr(5'h00, 8'h00);
    rdchk(5'h00, 8'h00);
    repeat (1800) @(posedge clk);
    rdchk(5'h10, 8'h00);
    rdchk(5'h08, expRes[11:4]);
    // reset in mid-conversion, after sampling, returns the control, high result and mode registers to zero
    wr(5'h00, 8'hc3);
    repeat (300) @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rdchk(5'h00, 8'h00);
    rdchk(5'h08, 8'h00);
    rdchk(5'h04, 8'h00);
    complete_run();
  end
endmodule
